// ===== asc_ctrl.sv
/*
 * Sample and conversion sequencer with APB register file and interrupt.
 * Assumes an APB master on CLK, external triggers and the RC clock tick
 * arriving asynchronously on pins.
 */
`timescale 1ns/1ps
`default_nettype none
module asc_ctrl #(
	parameter int CONVERT_PERIODS = asc_pkg::CONVERT_TAD
) (
	// Clock and reset.
	input  wire logic        CLK,
	input  wire logic        RESET,
	// APB slave.
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output var  logic [31:0] PRDATA,
	output var  logic        PREADY,
	output var  logic        PSLVERR,
	// External triggers and converter clock.
	input  wire logic [6:0]  TRIGGER_IN,
	input  wire logic        RC_CLOCK_TICK,
	// Analog side.
	output var  logic        SAMPLE_ENABLE,
	output var  logic        CONVERT_START,
	output var  logic        CONVERTING,
	output var  logic        CONVERSION_CLOCK_SOURCE,
	output var  logic        TAD_TICK,
	// Interrupt.
	output var  logic        IRQ
);
	import asc_pkg::*;

	asc_state_t       state;
	asc_state_t       next_state;
	logic [2:0]       trigger_source_select;
	logic             sample_auto_start;
	logic             done;
	logic [15:0]      clock_sample;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [7:0]       tad_count;
	logic [6:0]       trig_sync;
	logic [6:0]       trig_prev;
	logic             rc_sync;
	logic             rc_prev;
	logic             tad;

	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : g_trig
			asc_sync u_sync (
				.CLK      (CLK),
				.RESET    (RESET),
				.async_in (TRIGGER_IN[g]),
				.sync_out (trig_sync[g])
			);
		end
	endgenerate

	asc_sync u_rc_sync (
		.CLK      (CLK),
		.RESET    (RESET),
		.async_in (RC_CLOCK_TICK),
		.sync_out (rc_sync)
	);

	wire use_rc = clock_sample[CLK_SRC_BIT];

	asc_tad_gen #(.DIV_W(8)) u_tad (
		.CLK      (CLK),
		.RESET    (RESET),
		.use_rc   (use_rc),
		.divider  (clock_sample[DIV_MSB:DIV_LSB]),
		.rc_tick  (rc_sync & ~rc_prev),
		.tad_tick (tad)
	);

	// Bus decode.
	wire        access  = PSEL & PENABLE;
	wire        wr      = access & PWRITE;
	wire        hit_c1  = (PADDR == ADDR_CONTROL_ONE);
	wire        hit_c3  = (PADDR == ADDR_CLOCK_SAMPLE);
	wire        hit_st  = (PADDR == ADDR_IRQ_STATUS);
	wire        hit_mk  = (PADDR == ADDR_IRQ_MASK);
	wire        mapped  = hit_c1 | hit_c3 | hit_st | hit_mk;
	wire        wr_c1   = wr & hit_c1;
	wire [15:0] c1_read = {8'h00, trigger_source_select, 2'b00, sample_auto_start,
		SAMPLE_ENABLE, done};
	wire [31:0] rd_mux  = hit_c1 ? {16'h0000, c1_read} :
		hit_c3 ? {16'h0000, clock_sample} :
		hit_st ? {30'h0, irq_status} :
		hit_mk ? {30'h0, irq_mask} : 32'h0;

	// Trigger selection for the non-manual modes.
	wire [2:0] trig_in_sel = trigger_source_select - 3'h1;
	wire [6:0] trig_rise   = trig_sync & ~trig_prev;
	wire       manual      = (trigger_source_select == TRIG_MANUAL);
	wire       auto_conv   = (trigger_source_select == TRIG_AUTO_CONVERT);
	wire       samc_done   = tad & (tad_count >= {3'h0, clock_sample[SAMC_MSB:SAMC_LSB]});
	wire       hw_trigger  = auto_conv ? samc_done : trig_rise[trig_in_sel];
	wire       sw_set      = wr_c1 & PWDATA[BIT_SAMPLE] & ~SAMPLE_ENABLE;
	wire       sw_end      = wr_c1 & ~PWDATA[BIT_SAMPLE] & manual;
	wire       conv_end    = tad & (tad_count == 8'(CONVERT_PERIODS - 1));

	// Sequencer.
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE, ST_COMPLETE: begin
				if (sample_auto_start)
					next_state = ST_SAMPLING;
				else if (sw_set)
					next_state = ST_SAMPLING;
			end
			ST_SAMPLING: begin
				if (manual ? sw_end : hw_trigger)
					next_state = ST_CONVERTING;
			end
			ST_CONVERTING: begin
				if (conv_end)
					next_state = ST_COMPLETE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	wire start_conv = (state == ST_SAMPLING) && (next_state == ST_CONVERTING);
	wire finish     = (state == ST_CONVERTING) && conv_end;
	wire [IRQ_W-1:0] events = {start_conv, finish};

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			state     <= ST_IDLE;
			tad_count <= '0;
			trig_prev <= '0;
			rc_prev   <= 1'b0;
		end else begin
			state     <= next_state;
			trig_prev <= trig_sync;
			rc_prev   <= rc_sync;
			if (next_state != state)
				tad_count <= '0;
			else if (tad)
				tad_count <= tad_count + 8'h01;
		end
	end

	// Flag and status outputs.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			done          <= 1'b0;
			SAMPLE_ENABLE <= 1'b0;
			CONVERT_START <= 1'b0;
			CONVERTING    <= 1'b0;
		end else begin
			SAMPLE_ENABLE <= (next_state == ST_SAMPLING);
			CONVERT_START <= start_conv;
			CONVERTING    <= (next_state == ST_CONVERTING);
			if (finish)
				done <= 1'b1;
			else if (start_conv)
				done <= 1'b0;
			else if (wr_c1 & ~PWDATA[BIT_DONE])
				done <= 1'b0;
		end
	end

	// Registers and bus answer.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			trigger_source_select <= TRIG_MANUAL;
			sample_auto_start     <= 1'b0;
			clock_sample          <= CLOCK_SAMPLE_RESET;
			irq_mask              <= '0;
			irq_status            <= '0;
			PRDATA                <= '0;
			PREADY                <= 1'b0;
			PSLVERR               <= 1'b0;
			IRQ                   <= 1'b0;
			CONVERSION_CLOCK_SOURCE <= 1'b0;
			TAD_TICK              <= 1'b0;
		end else begin
			if (wr_c1) begin
				trigger_source_select <= PWDATA[TRIG_MSB:TRIG_LSB];
				sample_auto_start     <= PWDATA[BIT_AUTOSTART];
			end
			if (wr & hit_c3)
				clock_sample <= PWDATA[15:0] & CLOCK_SAMPLE_MASK;
			if (wr & hit_mk)
				irq_mask <= PWDATA[IRQ_W-1:0];
			// A new event wins over a write-one-to-clear in the same cycle.
			irq_status <= (irq_status & ~((wr & hit_st) ? PWDATA[IRQ_W-1:0] : '0)) | events;
			PREADY  <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & ~mapped;
			PRDATA  <= (PSEL & ~PENABLE & ~PWRITE) ? rd_mux : 32'h0;
			IRQ     <= |(irq_status & irq_mask);
			CONVERSION_CLOCK_SOURCE <= use_rc;
			TAD_TICK <= tad;
		end
	end
endmodule // asc_ctrl
`default_nettype wire

// ===== asc_pkg.sv
/*
 * Package for the converter sample and conversion control block: register
 * offsets, field positions, reset values, state type and timing constants.
 * Assumes a 32-bit APB slave with each register in one aligned word.
 */
// Overview of operation
// - Sample-enable bit: one means the amplifiers acquire, zero means they hold.
// - Without auto-start, software writing one to sample-enable starts sampling.
// - With auto-start, hardware sets sample-enable with no software write.
// - In manual trigger mode, software writing zero ends sampling and starts conversion.
// - In any other trigger mode, hardware clears sample-enable on the trigger.
// - Hardware sets the conversion-complete flag when a conversion finishes.
// - The conversion-complete flag reads zero before any conversion and while converting.
// - Software clears conversion-complete by writing zero and never sets it.
// - A software clear of conversion-complete leaves running operations untouched.
// - Hardware clears conversion-complete at the start of each new conversion.
// - With auto-start, sampling restarts right after a conversion ends.
// - Clock source bit 15 picks the internal RC clock or the divided system clock.
// - The auto-sample time field is used only with internal counter auto-convert.
// - Conversion clock period is system period times divider plus one, unless RC.
package asc_pkg;
	localparam logic [11:0] ADDR_CONTROL_ONE  = 12'h000;
	localparam logic [11:0] ADDR_CLOCK_SAMPLE = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK     = 12'h00c;

	localparam int BIT_DONE      = 0;
	localparam int BIT_SAMPLE    = 1;
	localparam int BIT_AUTOSTART = 2;
	localparam int TRIG_LSB      = 5;
	localparam int TRIG_MSB      = 7;
	localparam int CLK_SRC_BIT   = 15;
	localparam int SAMC_LSB      = 8;
	localparam int SAMC_MSB      = 12;
	localparam int DIV_LSB       = 0;
	localparam int DIV_MSB       = 7;

	localparam logic [15:0] CLOCK_SAMPLE_MASK  = 16'h9fff;
	localparam logic [15:0] CLOCK_SAMPLE_RESET = 16'h0000;
	localparam logic [2:0]  TRIG_MANUAL        = 3'h0;
	localparam logic [2:0]  TRIG_AUTO_CONVERT  = 3'h7;

	localparam int IRQ_BIT_DONE   = 0;
	localparam int IRQ_BIT_SAMPLE = 1;
	localparam int IRQ_W          = 2;

	// Conversion length in conversion clock periods.
	localparam int CONVERT_TAD = 12;
	localparam int SYNC_STAGES = 3;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLING,
		ST_CONVERTING,
		ST_COMPLETE
	} asc_state_t;
endpackage

// ===== asc_sync.sv
/*
 * Three-stage synchroniser with agreement filter for one external level.
 * Assumes the input may change at any time relative to CLK.
 */
`timescale 1ns/1ps
`default_nettype none
module asc_sync (
	// Clock and reset.
	input  wire logic CLK,
	input  wire logic RESET,
	// Level.
	input  wire logic async_in,
	output var  logic sync_out
);
	import asc_pkg::*;
	logic [SYNC_STAGES-1:0] stage;

	// A change counts only once the second and third stages agree.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			stage    <= '0;
			sync_out <= 1'b0;
		end else begin
			stage <= {stage[SYNC_STAGES-2:0], async_in};
			if (stage[1] == stage[2])
				sync_out <= stage[2];
		end
	end
endmodule // asc_sync
`default_nettype wire

// ===== asc_tad_gen.sv
/*
 * Conversion clock tick generator: divided system clock or the converter's
 * RC clock. Assumes the RC clock tick is already in the CLK domain.
 */
`timescale 1ns/1ps
`default_nettype none
module asc_tad_gen #(
	parameter int DIV_W = 8
) (
	// Clock and reset.
	input  wire logic             CLK,
	input  wire logic             RESET,
	// Selection.
	input  wire logic             use_rc,
	input  wire logic [DIV_W-1:0] divider,
	input  wire logic             rc_tick,
	// Tick out.
	output var  logic             tad_tick
);
	logic [DIV_W-1:0] count;
	wire              wrap = (count >= divider);

	// One tick every divider plus one system clocks; divider unused on RC.
	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			count    <= '0;
			tad_tick <= 1'b0;
		end else begin
			count    <= wrap ? '0 : count + 1'b1;
			tad_tick <= use_rc ? rc_tick : wrap;
		end
	end
endmodule // asc_tad_gen
`default_nettype wire

// ===== asc_chk.sv
/* Port checker for asc_ctrl.
   Assumes it is bound to asc_ctrl and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module asc_chk (
	// Watched ports.
	input wire logic        CLK,
	input wire logic        RESET,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        SAMPLE_ENABLE,
	input wire logic        CONVERT_START,
	input wire logic        CONVERTING
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	a_no_overlap: assert property (!(SAMPLE_ENABLE && CONVERTING))
		else $error("sample and convert overlap");
	a_hold_starts_conv: assert property ($fell(SAMPLE_ENABLE) |-> CONVERTING)
		else $error("hold without conversion");
	a_conv_min_length: assert property ($rose(CONVERTING) |-> CONVERTING [*8])
		else $error("conversion too short");
	a_start_with_conv: assert property (CONVERT_START |-> CONVERTING ##1 !CONVERT_START)
		else $error("bad start pulse");
	a_ready_wait_free: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no ready");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready held");
	a_err_with_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("stale read data");
	c_convert: cover property (CONVERT_START);
	c_done: cover property ($fell(CONVERTING));
	c_error: cover property (PSLVERR);
endmodule // asc_chk
bind asc_ctrl asc_chk u_chk (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE_ENABLE(SAMPLE_ENABLE),
	.CONVERT_START(CONVERT_START), .CONVERTING(CONVERTING));
`default_nettype wire

// ===== asc_analog.sv
/* Far-side model: trigger sources and a free-running RC oscillator.
   Assumes clk is the system clock of asc_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module asc_analog (
	// Ports.
	input  wire logic       clk,
	input  wire logic       sampling,
	input  wire logic [2:0] sel,
	output var  logic [6:0] trigger,
	output var  logic       rc_tick
);
	logic [3:0] age = 4'h0;
	logic [1:0] osc = 2'h0;
	// The selected source fires once sampling has lasted ten cycles.
	always @(posedge clk) begin
		age <= sampling ? age + 4'h1 : 4'h0;
		osc <= osc + 2'h1;
	end
	assign trigger = (age > 4'h9 && sel != 3'h0) ? 7'h01 << (sel - 3'h1) : 7'h00;
	assign rc_tick = osc[1];
endmodule // asc_analog
`default_nettype wire

// ===== asc_ctrl_tb_top.sv
/* Bench for asc_ctrl: APB tasks and directed scenarios.
   Assumes asc_pkg, asc_analog and asc_chk are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, a) begin checks_done++; if ((a) !== (x)) begin miscompares++; \
	$display("Error %s exp %h got %h", n, x, a); end end
module asc_ctrl_tb_top;
	import asc_pkg::*;
	localparam logic [11:0] C1 = ADDR_CONTROL_ONE, CS = ADDR_CLOCK_SAMPLE;
	localparam logic [11:0] ST = ADDR_IRQ_STATUS, MK = ADDR_IRQ_MASK;
	logic             clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
	logic [11:0]      paddr = 12'h0;
	logic [31:0]      pwdata = 32'h0, r;
	logic [2:0]       sel = 3'h0;
	int               miscompares = 0, checks_done = 0;
	wire logic [31:0] prdata;
	wire logic [6:0]  trig;
	wire logic        pready, pslverr, rc, sample_enable, cstart, conv, csrc, tick, irq;
	wire logic [3:0]  obs = {cstart, irq, conv, sample_enable};
	asc_ctrl dut (.CLK(clk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TRIGGER_IN(trig), .RC_CLOCK_TICK(rc), .SAMPLE_ENABLE(sample_enable), .CONVERT_START(cstart),
		.CONVERTING(conv), .CONVERSION_CLOCK_SOURCE(csrc), .TAD_TICK(tick), .IRQ(irq));
	asc_analog u_far (.clk(clk), .sampling(sample_enable), .sel(sel), .trigger(trig), .rc_tick(rc));
	always #5 clk = ~clk;
	task automatic print_verdict();
		if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Signals move just after a rising edge; ready, read data and error are read
	// right at the rising edge, so the values seen are those that edge samples.
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		`CHK("pready", 1'b1, pready)
		if (pready !== 1'b1) print_verdict();
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Measures the number of clocks from one conversion clock tick to the next.
	task automatic tk(input int x);
		int n;
		int k;
		n = 0;
		k = 0;
		repeat (4) @(posedge clk);
		do begin
			@(posedge clk);
			k++;
		end while (tick !== 1'b1 && k < 600);
		do begin
			@(posedge clk);
			n++;
		end while (tick !== 1'b1 && n < 600);
		`CHK("tad period", x, n)
		if (tick !== 1'b1) print_verdict();
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(a, 1'b0, 32'h0);
		`CHK("prdata", x, r)
	endtask
	task automatic wt(input int s, input logic v);
		for (int n = 0; n < 400; n++) begin
			@(posedge clk);
			#1;
			if (obs[s] === v) break;
		end
		`CHK("level", v, obs[s])
		if (obs[s] !== v) print_verdict();
	endtask
	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rd(CS, 32'h0);
		wr(CS, 32'hffff);
		rd(CS, 32'h9fff);
		apb(12'h010, 1'b0, 32'h0);
		`CHK("pslverr", 1'b1, e)
		wr(CS, 32'h0001);
		tk(2);
		wr(MK, 32'h1);
		wr(C1, 32'h2);
		wt(0, 1'b1);
		rd(C1, 32'h2);
		wr(C1, 32'h0);
		wt(1, 1'b1);
		rd(C1, 32'h0);
		wt(1, 1'b0);
		rd(C1, 32'h1);
		wt(2, 1'b1);
		rd(ST, 32'h3);
		wr(ST, 32'h3);
		wt(2, 1'b0);
		wr(C1, 32'h3);
		wr(C1, 32'h1);
		rd(C1, 32'h0);
		wr(C1, 32'h0);
		wt(1, 1'b0);
		rd(C1, 32'h1);
		wr(C1, 32'h0);
		rd(C1, 32'h0);
		for (int m = 1; m < 7; m++) begin
			sel <= 3'(m);
			wr(C1, 32'(m << 5) | 32'h2);
			wt(3, 1'b1);
			wt(1, 1'b1);
			wt(1, 1'b0);
			rd(C1, 32'(m << 5) | 32'h1);
		end
		sel <= 3'h0;
		wr(CS, 32'h0201);
		wr(C1, 32'he5);
		wt(0, 1'b1);
		wt(1, 1'b1);
		wt(1, 1'b0);
		wt(0, 1'b1);
		wr(C1, 32'h1);
		wt(1, 1'b0);
		wr(MK, 32'h0);
		wr(ST, 32'h3);
		wr(CS, 32'h80ff);
		wr(C1, 32'h2);
		wt(0, 1'b1);
		`CHK("source", 1'b1, csrc)
		tk(4);
		wr(C1, 32'h0);
		wt(1, 1'b1);
		wt(1, 1'b0);
		rd(ST, 32'h3);
		`CHK("irq", 1'b0, irq)
		print_verdict();
	end
endmodule // asc_ctrl_tb_top
`default_nettype wire
